/* File: hw/monitor_limit_pkg.sv */
// Purpose: Shared constants for the monitor limit compare bank.
// Assumes: APB word index = register index, byte address = index * 4.
// Notes:   Status bits of both status registers form one 16-bit space.
package monitor_limit_pkg;

  // ----------------------------------------------------------------
  // Register indexes
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS_ONE          = 8'h41;
  localparam logic [7:0] IDX_STATUS_TWO          = 8'h42;
  localparam logic [7:0] IDX_SUPPLY_A_LOW_LIMIT  = 8'h44;
  localparam logic [7:0] IDX_SUPPLY_A_HIGH_LIMIT = 8'h45;
  localparam logic [7:0] IDX_CORE_SUPPLY_LOW     = 8'h46;
  localparam logic [7:0] IDX_CORE_SUPPLY_HIGH    = 8'h47;
  localparam logic [7:0] IDX_MAIN_SUPPLY_LOW     = 8'h48;
  localparam logic [7:0] IDX_MAIN_SUPPLY_HIGH    = 8'h49;
  localparam logic [7:0] IDX_SUPPLY_B_LOW_LIMIT  = 8'h4a;
  localparam logic [7:0] IDX_SUPPLY_B_HIGH_LIMIT = 8'h4b;
  localparam logic [7:0] IDX_SUPPLY_C_LOW_LIMIT  = 8'h4c;
  localparam logic [7:0] IDX_SUPPLY_C_HIGH_LIMIT = 8'h4d;
  localparam logic [7:0] IDX_REMOTE_ONE_LOW_TEMP = 8'h4e;
  localparam logic [7:0] IDX_REMOTE_ONE_HIGH_TEMP = 8'h4f;
  localparam logic [7:0] IDX_INTERNAL_LOW_TEMP   = 8'h50;
  localparam logic [7:0] IDX_INTERNAL_HIGH_TEMP  = 8'h51;
  localparam logic [7:0] IDX_REMOTE_TWO_LOW_TEMP = 8'h52;
  localparam logic [7:0] IDX_REMOTE_TWO_HIGH_TEMP = 8'h53;
  localparam logic [7:0] IDX_FAN_ONE_MIN_LOW     = 8'h54;
  localparam logic [7:0] IDX_FAN_ONE_MIN_HIGH    = 8'h55;
  localparam logic [7:0] IDX_FAN_TWO_MIN_LOW     = 8'h56;
  localparam logic [7:0] IDX_FAN_TWO_MIN_HIGH    = 8'h57;
  localparam logic [7:0] IDX_FAN_THREE_MIN_LOW   = 8'h58;
  localparam logic [7:0] IDX_FAN_THREE_MIN_HIGH  = 8'h59;
  localparam logic [7:0] IDX_FAN_FOUR_MIN_LOW    = 8'h5a;
  localparam logic [7:0] IDX_FAN_FOUR_MIN_HIGH   = 8'h5b;
  localparam logic [7:0] IDX_ENABLE_ONE          = 8'h80;
  localparam logic [7:0] IDX_ENABLE_TWO          = 8'h81;
  localparam logic [7:0] IDX_MASK_ONE            = 8'h82;
  localparam logic [7:0] IDX_MASK_TWO            = 8'h83;

  // ----------------------------------------------------------------
  // Sizes and limit array layout
  // ----------------------------------------------------------------
  localparam int unsigned NUM_VOLT    = 5;
  localparam int unsigned NUM_TEMP    = 3;
  localparam int unsigned NUM_FAN     = 4;
  localparam int unsigned NUM_LIMIT   = 24;
  localparam int unsigned VOLT_SLOT   = 0;
  localparam int unsigned TEMP_SLOT   = 10;
  localparam int unsigned FAN_SLOT    = 16;

  // ----------------------------------------------------------------
  // Reset values and special codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  VOLT_LOW_RST  = 8'h00;
  localparam logic [7:0]  VOLT_HIGH_RST = 8'hff;
  localparam logic [7:0]  TEMP_LOW_RST  = 8'h81;
  localparam logic [7:0]  TEMP_HIGH_RST = 8'h7f;
  localparam logic [7:0]  FAN_MIN_RST   = 8'hff;
  localparam logic [15:0] ENABLE_RST    = 16'h3d7f;
  localparam logic [15:0] MASK_RST      = 16'h0000;
  localparam logic [15:0] STATUS_RST    = 16'h0000;
  localparam logic [15:0] FAN_NEVER     = 16'hffff;
  localparam logic [7:0]  DUTY_OFF      = 8'h00;
  localparam logic [7:0]  VOLT_NOMINAL  = 8'hc0;

  // ----------------------------------------------------------------
  // Status bit positions in the 16-bit event space
  // ----------------------------------------------------------------
  localparam int unsigned ST_VOLT_BASE  = 0;
  localparam int unsigned ST_TEMP_BASE  = 4;
  localparam int unsigned ST_SUMMARY    = 7;
  localparam int unsigned ST_SUPPLY_C   = 8;
  localparam int unsigned ST_FAN_BASE   = 10;

endpackage : monitor_limit_pkg

/* File: hw/monitor_limit_compare_bank.sv */
// Purpose: Limit registers and compare logic of a hardware monitor.
// Assumes: Readings arrive on clk_i with a one-cycle update strobe.
// Notes:   APB slave, zero wait states, one interrupt level output.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps

module monitor_limit_compare_bank (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [9:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [39:0] volt_reading_i,
  input  wire logic [4:0]  volt_update_i,
  input  wire logic [23:0] temp_reading_i,
  input  wire logic [2:0]  temp_update_i,
  input  wire logic [63:0] fan_count_i,
  input  wire logic [3:0]  fan_update_i,
  input  wire logic [31:0] fan_duty_i,
  input  wire logic [3:0]  fan_pwm_disabled_i,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Byte address is four times the index; only bits 7:0 carry data.
  // Index 41 status one, sticky, write one to clear.
  //   bit 0 supply A, 1 core, 2 main, 3 supply B
  //   bit 4 remote one, 5 internal, 6 remote two
  //   bit 7 summary, OR of status two, read only
  // Index 42 status two, sticky, write one or qualified read clears.
  //   bit 0 supply C, bits 2 to 5 fans one to four
  //   bits 1, 6 and 7 always read zero
  // Index 44 to 4D supply limit pairs, low then high.
  // Index 4E to 53 temperature limit pairs, low then high.
  // Index 54 to 5B fan minimum pairs, low byte then high byte.
  // Index 80 and 81 enables, same layout as the two status bytes.
  // Index 82 and 83 masks, same layout as the two status bytes.
  // Any other index, or a misaligned address, answers with an error.
  //
  // ----------------------------------------------------------------
  // Reading interface
  // ----------------------------------------------------------------
  // Each reading comes with a one-cycle update pulse.
  // The compare is made at the edge that samples the pulse.
  // Limits used are those that stand at that same edge.
  // A limit write and a reading in one cycle use the old limit.
  // Readings without a pulse are ignored, whatever they show.
  // Pulses may come every cycle and in any order.
  //
  // Supply readings: unsigned, nominal level near three quarters.
  // Temperature readings: signed, whole degrees.
  // Fan readings: clock counts, so a larger count is a slower fan.
  //
  // ----------------------------------------------------------------
  // Flag behaviour
  // ----------------------------------------------------------------
  // A flag sets on an update whose compare fails while enabled.
  // A flag clears on an update while its enable bit is low,
  // so software can silence a noisy input without a clear write.
  // A set and a clear in one cycle: the set wins, no event lost.
  // Status two clears on a read only while no enabled event there
  // is still failing; the last compare result decides this.
  // The interrupt level follows flags and mask one cycle later.
  //
  // ----------------------------------------------------------------
  // Fan qualifiers
  // ----------------------------------------------------------------
  // A fan with duty zero or a disabled drive is not judged,
  // since a stopped fan would read as stalled for ever.
  // A minimum of all ones turns the fan check off entirely.
  // Software must keep minimum counts high enough for the slowest normal running,
  // or normal slow spinning can be flagged now and then.
  //
  // ----------------------------------------------------------------
  // Bus timing
  // ----------------------------------------------------------------
  // Setup cycle: answer and read data are prepared and registered.
  // Access cycle: ready stands high for exactly one cycle.
  // Writes and read side effects act at the completing edge only.
  // Read data hold until the next setup cycle.
  // Back-to-back transfers are accepted with no idle cycle.
  //
  // ----------------------------------------------------------------
  // Limitations
  // ----------------------------------------------------------------
  // No write protection: limits stay writable at all times.
  // Fault flags of the diodes are not handled in this block.
  // Reserved status bits are tied low and never update.
  // The limit array is small, so it lives in flip-flops.
  //
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]  limit_q [monitor_limit_pkg::NUM_LIMIT];
  logic [15:0] status;
  logic [15:0] active;
  logic [15:0] enable;
  logic [15:0] mask;
  logic [15:0] hit;
  logic [15:0] upd;
  logic [7:0]  idx;
  logic [7:0]  slot;
  logic        in_limit;
  logic        aligned;
  logic        setup;
  logic        done;
  logic        wr_done;
  logic        rd_done;
  logic [7:0]  next_rdata;
  logic        next_err;
  logic [7:0]  wbyte;

  assign idx      = paddr_i[9:2];
  assign aligned  = (paddr_i[1:0] == 2'b00);
  assign slot     = idx - monitor_limit_pkg::IDX_SUPPLY_A_LOW_LIMIT;
  assign in_limit = aligned
                    && (idx >= monitor_limit_pkg::IDX_SUPPLY_A_LOW_LIMIT)
                    && (idx <= monitor_limit_pkg::IDX_FAN_FOUR_MIN_HIGH);
  assign setup    = psel_i && !penable_i;
  assign done     = psel_i && penable_i && pready_o;
  assign wr_done  = done && pwrite_i;
  assign rd_done  = done && !pwrite_i;
  assign wbyte    = pwdata_i[7:0];

  // ----------------------------------------------------------------
  // Compare logic
  // ----------------------------------------------------------------
  // Unused event bits never update, so their flags stay zero
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_unused
      if (!((g < 7) || (g == 8) || ((g >= 10) && (g < 14)))) begin : g_off
        assign hit[g] = 1'b0;
        assign upd[g] = 1'b0;
      end
    end

    // Supplies A, core, main, B in status one; supply C in status two
    for (g = 0; g < 5; g++) begin : g_volt
      localparam int unsigned BIT =
        (g < 4) ? monitor_limit_pkg::ST_VOLT_BASE + g
                : monitor_limit_pkg::ST_SUPPLY_C;
      localparam int unsigned LO = monitor_limit_pkg::VOLT_SLOT + 2 * g;
      logic [7:0] rd;
      assign rd = volt_reading_i[8*g +: 8];
      // Unsigned 8-bit scale, nominal at three quarters of full scale
      assign hit[BIT] = (rd > limit_q[LO + 1])
                        || (rd <= limit_q[LO]);
      assign upd[BIT] = volt_update_i[g];
    end

    // Remote one lands on bit 4, internal bit 5, remote two bit 6
    for (g = 0; g < 3; g++) begin : g_temp
      localparam int unsigned BIT = monitor_limit_pkg::ST_TEMP_BASE + g;
      localparam int unsigned LO = monitor_limit_pkg::TEMP_SLOT + 2 * g;
      logic signed [7:0] rd;
      assign rd = $signed(temp_reading_i[8*g +: 8]);
      assign hit[BIT] = (rd > $signed(limit_q[LO + 1]))
                        || (rd <= $signed(limit_q[LO]));
      assign upd[BIT] = temp_update_i[g];
    end

    // Fan counts grow as the fan slows, so above the minimum is bad
    for (g = 0; g < 4; g++) begin : g_fan
      localparam int unsigned BIT = monitor_limit_pkg::ST_FAN_BASE + g;
      localparam int unsigned LO = monitor_limit_pkg::FAN_SLOT + 2 * g;
      logic [15:0] lim;
      logic        quiet;
      assign lim = {limit_q[LO + 1], limit_q[LO]};
      // Stopped or disabled fans would always look stalled
      assign quiet = (fan_duty_i[8*g +: 8] == monitor_limit_pkg::DUTY_OFF)
                     || fan_pwm_disabled_i[g];
      assign hit[BIT] = (fan_count_i[16*g +: 16] > lim)
                        && (lim != monitor_limit_pkg::FAN_NEVER)
                        && !quiet;
      assign upd[BIT] = fan_update_i[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Limit registers
  // ----------------------------------------------------------------
  // Always writable: there is no lock input by design
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < monitor_limit_pkg::NUM_LIMIT; i++) begin
        if (i < monitor_limit_pkg::TEMP_SLOT) begin
          limit_q[i] <= (i % 2 == 0) ? monitor_limit_pkg::VOLT_LOW_RST
                                     : monitor_limit_pkg::VOLT_HIGH_RST;
        end else if (i < monitor_limit_pkg::FAN_SLOT) begin
          limit_q[i] <= (i % 2 == 0) ? monitor_limit_pkg::TEMP_LOW_RST
                                     : monitor_limit_pkg::TEMP_HIGH_RST;
        end else begin
          limit_q[i] <= monitor_limit_pkg::FAN_MIN_RST;
        end
      end
    end else if (wr_done && in_limit) begin
      limit_q[slot[4:0]] <= wbyte;
    end
  end

  // ----------------------------------------------------------------
  // Enable and mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      enable <= monitor_limit_pkg::ENABLE_RST;
      mask   <= monitor_limit_pkg::MASK_RST;
    end else if (wr_done && aligned) begin
      unique case (idx)
        monitor_limit_pkg::IDX_ENABLE_ONE: enable[7:0]  <= wbyte;
        monitor_limit_pkg::IDX_ENABLE_TWO: enable[15:8] <= wbyte;
        monitor_limit_pkg::IDX_MASK_ONE:   mask[7:0]    <= wbyte;
        monitor_limit_pkg::IDX_MASK_TWO:   mask[15:8]   <= wbyte;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Event activity
  // ----------------------------------------------------------------
  // Last compare result per event, used to hold status two on read
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      active <= monitor_limit_pkg::STATUS_RST;
    end else begin
      for (int b = 0; b < 16; b++) begin
        if (upd[b]) begin
          active[b] <= hit[b];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky status
  // ----------------------------------------------------------------
  // A fresh violation beats any clear in the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status <= monitor_limit_pkg::STATUS_RST;
    end else begin
      for (int b = 0; b < 16; b++) begin
        if (upd[b] && hit[b] && enable[b]) begin
          status[b] <= 1'b1;
        end else if (upd[b] && !enable[b]) begin
          status[b] <= 1'b0;
        end else if (wr_done && aligned && (b < 8)
                     && (idx == monitor_limit_pkg::IDX_STATUS_ONE)
                     && wbyte[b % 8]) begin
          status[b] <= 1'b0;
        end else if (wr_done && aligned && (b >= 8)
                     && (idx == monitor_limit_pkg::IDX_STATUS_TWO)
                     && wbyte[b % 8]) begin
          status[b] <= 1'b0;
        end else if (rd_done && aligned && (b >= 8)
                     && (idx == monitor_limit_pkg::IDX_STATUS_TWO)
                     && !(|(active[15:8] & enable[15:8]))) begin
          status[b] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    next_err   = 1'b0;
    if (in_limit) begin
      next_rdata = limit_q[slot[4:0]];
    end else if (!aligned) begin
      next_err = 1'b1;
    end else begin
      unique case (idx)
        monitor_limit_pkg::IDX_STATUS_ONE: begin
          next_rdata = status[7:0];
          // Summary bit mirrors any flag in status two
          next_rdata[monitor_limit_pkg::ST_SUMMARY] = |status[15:8];
        end
        monitor_limit_pkg::IDX_STATUS_TWO: next_rdata = status[15:8];
        monitor_limit_pkg::IDX_ENABLE_ONE: next_rdata = enable[7:0];
        monitor_limit_pkg::IDX_ENABLE_TWO: next_rdata = enable[15:8];
        monitor_limit_pkg::IDX_MASK_ONE:   next_rdata = mask[7:0];
        monitor_limit_pkg::IDX_MASK_TWO:   next_rdata = mask[15:8];
        default:                           next_err   = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // Answer prepared in setup so the access phase ends in one cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else if (setup) begin
      pready_o  <= 1'b1;
      pslverr_o <= next_err;
      prdata_o  <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, next_rdata};
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  // Registered, so it trails the status flags by one cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
    end
  end

endmodule : monitor_limit_compare_bank

/* File: verif/monitor_limit_checker.sv */
// Purpose: Port assertions for the monitor limit compare bank.
// Assumes: One clock domain, zero-wait APB answers.
// Notes:   Bound to the design below the module.
`timescale 1ns/1ps
module monitor_limit_checker (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [9:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [4:0]  volt_update_i,
  input wire logic [2:0]  temp_update_i,
  input wire logic [3:0]  fan_update_i,
  input wire logic        irq_o
);
  // ------------
  // Sequences
  // ------------
  logic cause;
  // Only a reading or a finished access may move the interrupt
  assign cause = |{volt_update_i, temp_update_i, fan_update_i,
                   psel_i & penable_i & pready_o};
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_pulse;
    pready_o ##1 !pready_o;
  endsequence
  // ------------
  // Assertions
  // ------------
  a_ready_pulse: assert property (s_setup |=> s_pulse)
    else $error("ready is not a one cycle answer");
  a_ready_cause: assert property (pready_o |->
    $past(psel_i) && !$past(penable_i)) else $error("ready without setup");
  a_limit_no_err: assert property (s_setup ##0 paddr_i[1:0] == 2'b00 &&
    paddr_i[9:2] inside {[8'h44:8'h5b]} |=> !pslverr_o)
    else $error("limit access refused");
  a_low_err: assert property (s_setup ##0 paddr_i[9:2] < 8'h41 |=> pslverr_o)
    else $error("unmapped access accepted");
  a_odd_read: assert property (s_setup ##0 !pwrite_i && paddr_i[1:0] != 2'b00
    |=> pslverr_o && prdata_o == 32'h0) else $error("misaligned read");
  a_byte_data: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("read data above one byte");
  a_irq_rise: assert property ($rose(irq_o) |-> $past(cause, 2))
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(irq_o) |-> $past(cause, 2))
    else $error("interrupt fell without cause");
  a_reset_quiet: assert property ($rose(arst_n_i) |-> !irq_o && !pready_o)
    else $error("outputs busy after reset");
endmodule : monitor_limit_checker
bind monitor_limit_compare_bank monitor_limit_checker chk_u (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .volt_update_i(volt_update_i), .temp_update_i(temp_update_i),
  .fan_update_i(fan_update_i), .irq_o(irq_o));

/* File: verif/sensor_model.sv */
// Purpose: Far-side model of supplies, diodes and fan tachometers.
// Assumes: Shares the bank's clock; update pulses one cycle wide.
// Notes:   Reading buses are inverted outside their update cycle.
`timescale 1ns/1ps
module sensor_model (
  input  wire logic        clk_i,
  output logic      [39:0] volt_reading_o,
  output logic      [23:0] temp_reading_o,
  output logic      [63:0] fan_count_o,
  output logic      [11:0] update_o,
  output logic      [31:0] fan_duty_o,
  output logic      [3:0]  fan_pwm_disabled_o
);
  // ------------
  // Stimulus
  // ------------
  initial begin
    {volt_reading_o, temp_reading_o, fan_count_o, update_o} = '0;
    fan_duty_o         = 32'h8080_8080;
    fan_pwm_disabled_o = 4'h0;
  end
  // Kind 0 supply, 1 diode, 2 fan; stale values never linger
  task automatic send(input int k, input int n, input logic [15:0] v);
    @(posedge clk_i);
    if (k == 0) volt_reading_o[8*n+:8] <= v[7:0];
    if (k == 1) temp_reading_o[8*n+:8] <= v[7:0];
    if (k == 2) fan_count_o[16*n+:16] <= v;
    update_o <= 12'h1 << (k == 2 ? 8 + n : 5 * k + n);
    @(posedge clk_i);
    update_o       <= 12'h0;
    volt_reading_o <= ~volt_reading_o;
    temp_reading_o <= ~temp_reading_o;
    fan_count_o    <= ~fan_count_o;
  endtask : send
  // Current duty and PWM switch of one fan
  task automatic pwm(input int n, input logic [7:0] d, input logic off);
    @(posedge clk_i);
    fan_duty_o[8*n+:8]    <= d;
    fan_pwm_disabled_o[n] <= off;
  endtask : pwm
endmodule : sensor_model

/* File: verif/tb.sv */
// Purpose: Self-checking bench for the monitor limit compare bank.
// Assumes: Zero-wait APB slave, one byte per aligned word.
// Notes:   APB answers are noted in a queue, popped by a monitor.
`timescale 1ns/1ps
module tb;
  logic        clk_i, arst_n_i, psel_i, penable_i, pwrite_i;
  logic        pready_o, pslverr_o, irq_o;
  logic [9:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, fan_duty_i;
  logic [39:0] volt_reading_i;
  logic [23:0] temp_reading_i;
  logic [63:0] fan_count_i;
  logic [11:0] upd;
  logic [3:0]  fan_pwm_disabled_i;
  logic [33:0] notes[$];
  logic [33:0] cur;
  logic [7:0]  hi, lo, v[24];
  int          n_errors, n_tests, i;
  monitor_limit_compare_bank dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
    .volt_reading_i(volt_reading_i), .volt_update_i(upd[4:0]),
    .temp_reading_i(temp_reading_i), .temp_update_i(upd[7:5]),
    .fan_count_i(fan_count_i), .fan_update_i(upd[11:8]),
    .fan_duty_i(fan_duty_i), .fan_pwm_disabled_i(fan_pwm_disabled_i));
  sensor_model sens_u (.clk_i(clk_i), .volt_reading_o(volt_reading_i),
    .temp_reading_o(temp_reading_i), .fan_count_o(fan_count_i),
    .update_o(upd), .fan_duty_o(fan_duty_i),
    .fan_pwm_disabled_o(fan_pwm_disabled_i));
  // ------------
  // Tasks
  // ------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // Note layout: compare data, slave error, expected data
  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [7:0] d, input logic [33:0] e);
    int k;
    notes.push_back(e);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    for (k = 0; k < 16 && pready_o !== 1'b1; k++) @(posedge clk_i);
    if (k == 16) begin
      n_errors++;
      finish_test();
    end
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, {a, 2'b00}, d, 34'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, {a, 2'b00}, 8'h0, {2'b10, 24'h0, e});
  endtask : rd
  // Clears both status bytes, sends a reading, reads its flag
  task automatic hit(input int k, input int n, input logic [15:0] r,
                     input logic e);
    int p;
    p = k == 0 ? (n == 4 ? 8 : n) : (k == 1 ? 4 + n : 10 + n);
    wr(8'h41, 8'hff);
    wr(8'h42, 8'hff);
    sens_u.send(k, n, r);
    rd(p < 8 ? 8'h41 : 8'h42, e ? 8'h01 << p[2:0] : 8'h00);
  endtask : hit
  task automatic irq_is(input logic e);
    repeat (2) @(negedge clk_i);
    check({31'h0, irq_o}, {31'h0, e});
  endtask : irq_is
  // Oldest note meets each completed access
  always @(posedge clk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && notes.size() > 0) begin
      cur = notes.pop_front();
      check({31'h0, pslverr_o}, {31'h0, cur[32]});
      if (cur[33]) check(prdata_o, cur[31:0]);
    end
  end
  // ------------
  // Scenarios
  // ------------
  initial begin
    {arst_n_i, psel_i, penable_i, pwrite_i} = 4'h0;
    paddr_i  = 10'h0;
    pwdata_i = 32'h0;
    void'($urandom(61));
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (i = 0; i < 24; i++) rd(8'h44 + 8'(i), i > 15 ? 8'hff : i > 9 ?
      (i[0] ? 8'h7f : 8'h81) : {8{i[0]}});
    rd(8'h80, 8'h7f);
    rd(8'h81, 8'h3d);
    rd(8'h82, 8'h00);
    rd(8'h42, 8'h00);
    $display("test reset values done");
    for (i = 0; i < 24; i++) begin
      v[i] = 8'($urandom);
      wr(8'h44 + 8'(i), v[i]);
    end
    apb(1'b1, 10'h112, 8'haa, 34'h1_0000_0000);
    for (i = 0; i < 24; i++) rd(8'h44 + 8'(i), v[i]);
    apb(1'b0, 10'h0fc, 8'h0, 34'h3_0000_0000);
    apb(1'b0, 10'h10c, 8'h0, 34'h3_0000_0000);
    apb(1'b0, 10'h111, 8'h0, 34'h3_0000_0000);
    $display("test register access done");
    for (i = 0; i < 5; i++) begin
      hi = 8'h80 + 8'($urandom_range(126));
      lo = 8'($urandom_range(126));
      wr(8'h44 + 8'(2 * i), lo);
      wr(8'h45 + 8'(2 * i), hi);
      hit(0, i, hi + 1, 1'b1);
      hit(0, i, hi, 1'b0);
      hit(0, i, lo, 1'b1);
      hit(0, i, lo + 1, 1'b0);
    end
    wr(8'h45, 8'hff);
    hit(0, 0, 16'hc0, 1'b0);
    for (i = 0; i < 3; i++) begin
      wr(8'h4e + 8'(2 * i), 8'hce);
      wr(8'h4f + 8'(2 * i), 8'h32);
      hit(1, i, 16'h33, 1'b1);
      hit(1, i, 16'h32, 1'b0);
      hit(1, i, 16'hce, 1'b1);
      hit(1, i, 16'hcf, 1'b0);
      hit(1, i, 16'h00, 1'b0);
    end
    $display("test supply and diode limits done");
    for (i = 0; i < 4; i++) begin
      wr(8'h54 + 8'(2 * i), 8'h34);
      wr(8'h55 + 8'(2 * i), 8'h12);
      hit(2, i, 16'h1235, 1'b1);
      hit(2, i, 16'h1234, 1'b0);
      hit(2, i, 16'h3412, 1'b1);
      sens_u.pwm(i, 8'h00, 1'b0);
      hit(2, i, 16'h1235, 1'b0);
      sens_u.pwm(i, 8'h80, 1'b1);
      hit(2, i, 16'h1235, 1'b0);
      sens_u.pwm(i, 8'h80, 1'b0);
      wr(8'h54 + 8'(2 * i), 8'hff);
      wr(8'h55 + 8'(2 * i), 8'hff);
      hit(2, i, 16'hffff, 1'b0);
    end
    $display("test fan limits done");
    wr(8'h44, 8'h40);
    wr(8'h45, 8'h80);
    wr(8'h82, 8'h01);
    hit(0, 0, 16'h90, 1'b1);
    irq_is(1'b1);
    wr(8'h82, 8'h00);
    irq_is(1'b0);
    wr(8'h82, 8'h01);
    irq_is(1'b1);
    wr(8'h41, 8'h01);
    irq_is(1'b0);
    wr(8'h80, 8'h7e);
    hit(0, 0, 16'h90, 1'b0);
    wr(8'h80, 8'h7f);
    $display("test interrupt done");
    wr(8'h4c, 8'h40);
    wr(8'h4d, 8'h80);
    hit(0, 4, 16'h90, 1'b1);
    rd(8'h41, 8'h80);
    rd(8'h42, 8'h01);
    sens_u.send(0, 4, 16'h60);
    rd(8'h42, 8'h01);
    rd(8'h42, 8'h00);
    $display("test status two clear done");
    finish_test();
  end
endmodule : tb
